// ---- design/pcd_pkg.sv ----
// Package: register map, fields, reset values and timing for PHY maintenance
`default_nettype none
package pcd_pkg;
   // -------------------------------------------------------------
   // Register offsets (word index on the plain register port)
   // -------------------------------------------------------------
   localparam logic [3:0] OFF_BASIC_CTRL = 4'h0;
   localparam logic [3:0] OFF_GIG_CTRL = 4'h1;
   localparam logic [3:0] OFF_DIAG = 4'h2;
   localparam logic [3:0] OFF_ADVERT = 4'h3;
   localparam logic [3:0] OFF_REM_LOOP = 4'h4;
   localparam logic [3:0] OFF_IND_MODE = 4'h5;
   localparam logic [3:0] OFF_PORT_STAT = 4'h6;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int BC_AN_ENABLE = 12;
   localparam int BC_AN_RESTART = 9;
   localparam int DG_START = 15;
   localparam int DG_PAIR_HI = 13;
   localparam int DG_PAIR_LO = 12;
   localparam int DG_STAT_HI = 9;
   localparam int DG_STAT_LO = 8;
   localparam int IM_SINGLE = 4;
   localparam int RL_ENABLE = 8;
   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [15:0] RST_BASIC_CTRL = 16'h1340;
   localparam logic [15:0] RST_GIG_CTRL = 16'h0700;
   localparam logic [15:0] RST_DIAG = 16'h0000;
   localparam logic [15:0] RST_ADVERT = 16'h01E1;
   localparam logic [15:0] RST_REM_LOOP = 16'h0000;
   localparam logic [15:0] RST_IND_MODE = 16'h0000;
   // -------------------------------------------------------------
   // Diagnostic outcome codes
   // -------------------------------------------------------------
   localparam logic [1:0] ST_NORMAL = 2'h0;
   localparam logic [1:0] ST_OPEN = 2'h1;
   localparam logic [1:0] ST_SHORT = 2'h2;
   localparam logic [1:0] ST_INVALID = 2'h3;
   // Speed codes of the link status input
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int BLINK_MS = 50;
   localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
   localparam int PULSE_NS = 80;
   localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int QUIET_TIMEOUT_CYC = 4000;
   localparam int ECHO_WINDOW_CYC = 255;
endpackage : pcd_pkg
`default_nettype wire

// ---- design/pcd_blink.sv ----
// Activity stretcher and blink enable for one indicator pair
`default_nettype none
module pcd_blink #(
   parameter int HALF_PERIOD = pcd_pkg::BLINK_CYC
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic activity,
   output logic blink_on,
   output logic phase
);
   // -------------------------------------------------------------
   // Period divider
   // -------------------------------------------------------------
   initial begin
      if (HALF_PERIOD < 2) $error("pcd_blink: period too short");
   end
   logic [31:0] cnt_q;
   logic tick;
   assign tick = (cnt_q == 32'(HALF_PERIOD - 1));
   // Free running divider makes the one-cycle tick
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) cnt_q <= 32'h0000_0000;
      else if (tick) cnt_q <= 32'h0000_0000;
      else cnt_q <= cnt_q + 32'h0000_0001;
   end
   // Pending activity held until the next tick starts a blink, so short
   // frames are never lost between ticks
   logic pend_q;
   logic on_q;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) pend_q <= 1'b0;
      else if (activity) pend_q <= 1'b1;
      else if (tick) pend_q <= 1'b0;
   end
   // Blink lasts three half periods, phase toggling at each tick
   logic [1:0] span_q;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         span_q <= 2'h0;
         on_q <= 1'b0;
         phase <= 1'b0;
      end else if (tick) begin
         if (pend_q || activity) begin
            span_q <= 2'h2;
            on_q <= 1'b1;
            phase <= ~phase;
         end else if (span_q != 2'h0) begin
            span_q <= span_q - 2'h1;
            phase <= ~phase;
         end else begin
            on_q <= 1'b0;
            phase <= 1'b0;
         end
      end
   end
   assign blink_on = on_q;
endmodule // pcd_blink
`default_nettype wire

// ---- design/pcd_tdr.sv ----
// Reflectometry sequencer: silence partner, pulse, time the echo
`default_nettype none
module pcd_tdr #(
   parameter int QUIET_TIMEOUT = pcd_pkg::QUIET_TIMEOUT_CYC
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [1:0] pair,
   input wire logic partner_quiet,
   input wire logic echo_seen,
   input wire logic echo_open,
   output logic busy,
   output logic done,
   output logic [1:0] status,
   output logic [7:0] result,
   output logic [3:0] pulse_pair
);
   typedef enum logic [4:0] {
      PCD_IDLE = 5'b00001,
      PCD_QUIET = 5'b00010,
      PCD_PULSE = 5'b00100,
      PCD_LISTEN = 5'b01000,
      PCD_DONE = 5'b10000
   } pcd_tdr_e;
   initial begin
      if (QUIET_TIMEOUT < 1) $error("pcd_tdr: bad timeout");
   end
   pcd_tdr_e st_q;
   logic [31:0] tmr_q;
   logic [1:0] pair_q;
   // -------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= PCD_IDLE;
         tmr_q <= 32'h0000_0000;
         pair_q <= 2'h0;
         status <= pcd_pkg::ST_NORMAL;
         result <= 8'h00;
      end else begin
         case (st_q)
            PCD_IDLE: begin
               if (start) begin
                  pair_q <= pair;
                  tmr_q <= 32'h0000_0000;
                  st_q <= PCD_QUIET;
               end
            end
            PCD_QUIET: begin
               tmr_q <= tmr_q + 32'h0000_0001;
               if (partner_quiet) begin
                  tmr_q <= 32'h0000_0000;
                  st_q <= PCD_PULSE;
               end else if (tmr_q == 32'(QUIET_TIMEOUT - 1)) begin
                  status <= pcd_pkg::ST_INVALID;
                  result <= 8'h00;
                  st_q <= PCD_DONE;
               end
            end
            PCD_PULSE: begin
               tmr_q <= tmr_q + 32'h0000_0001;
               if (tmr_q == 32'(pcd_pkg::PULSE_CYC - 1)) begin
                  tmr_q <= 32'h0000_0000;
                  st_q <= PCD_LISTEN;
               end
            end
            // delay gives distance, shape gives fault
            PCD_LISTEN: begin
               tmr_q <= tmr_q + 32'h0000_0001;
               if (echo_seen) begin
                  status <= echo_open ? pcd_pkg::ST_OPEN
                                      : pcd_pkg::ST_SHORT;
                  // raw echo delay is the result
                  result <= tmr_q[7:0];
                  st_q <= PCD_DONE;
               end else if (tmr_q == 32'(pcd_pkg::ECHO_WINDOW_CYC)) begin
                  status <= pcd_pkg::ST_NORMAL;
                  result <= 8'h00;
                  st_q <= PCD_DONE;
               end
            end
            PCD_DONE: st_q <= PCD_IDLE;
            default: st_q <= PCD_IDLE;
         endcase
      end
   end
   assign busy = (st_q != PCD_IDLE);
   assign done = (st_q == PCD_DONE);
   // one pair driven at a time
   assign pulse_pair = (st_q == PCD_PULSE) ? (4'h1 << pair_q) : 4'h0;
endmodule // pcd_tdr
`default_nettype wire

// ---- design/pcd_top.sv ----
// PHY maintenance: cable diagnostics, remote loopback, indicators
//
// What this block does
// - Diagnose one pair of one PHY only
// - Start bit 15 launches, self-clears at end
// - Status bits 9:8: normal, open, short, invalid
// - Partner not silenced: skip test, report invalid
// - Raw result in bits 7:0 for faults
// - Pair codes 00..11 select pairs A..D
// - Fixed pulse on pair, echo gives fault
// - Remote loopback returns line data to partner
// - Bit 4 of mode register picks indicator mode
// - Two active-low indicator outputs per port
// - Single mode: B link, A activity blink
// - Tri-colour: speed picks outputs, activity blinks
// - Basic control bit 9 restarts negotiation
//
// Implementation choices: the placing of the registers and strobed register access.
`default_nettype none
module pcd_top #(
   parameter int BLINK_HALF = pcd_pkg::BLINK_CYC,
   parameter int QUIET_TIMEOUT = pcd_pkg::QUIET_TIMEOUT_CYC,
   parameter int DATA_W = 8
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic link_up,
   input wire logic [1:0] link_speed,
   input wire logic rx_activity,
   input wire logic tx_activity,
   input wire logic partner_quiet,
   input wire logic echo_seen,
   input wire logic echo_open,
   input wire logic [DATA_W-1:0] line_rx_data,
   input wire logic line_rx_valid,
   input wire logic [DATA_W-1:0] mac_tx_data,
   input wire logic mac_tx_valid,
   output logic [DATA_W-1:0] line_tx_data,
   output logic line_tx_valid,
   output logic [3:0] pulse_pair,
   output logic an_restart,
   output logic port_indicator_a_n,
   output logic port_indicator_b_n
);
   initial begin
      if (DATA_W < 1) $error("pcd_top: DATA_W must be positive");
   end
   // -------------------------------------------------------------
   // Input synchronisers for pin-side status levels
   // -------------------------------------------------------------
   logic [6:0] sync1_q;
   logic [6:0] sync2_q;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= 7'h00;
         sync2_q <= 7'h00;
      end else begin
         sync1_q <= {link_up, link_speed, rx_activity, tx_activity,
                     partner_quiet, echo_seen};
         sync2_q <= sync1_q;
      end
   end
   logic s_link;
   logic [1:0] s_speed;
   logic s_act;
   logic s_quiet;
   logic s_echo;
   logic open_q1;
   logic open_q2;
   assign s_link = sync2_q[6];
   assign s_speed = sync2_q[5:4];
   assign s_act = sync2_q[3] | sync2_q[2];
   assign s_quiet = sync2_q[1];
   assign s_echo = sync2_q[0];
   // Echo shape passes the same two stages as its strobe
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         open_q1 <= 1'b0;
         open_q2 <= 1'b0;
      end else begin
         open_q1 <= echo_open;
         open_q2 <= open_q1;
      end
   end
   // -------------------------------------------------------------
   // Register file
   // -------------------------------------------------------------
   logic [15:0] basic_q;
   logic [15:0] gig_q;
   logic [15:0] adv_q;
   logic [15:0] loop_q;
   logic [15:0] mode_q;
   logic [1:0] pair_q;
   logic start_q;
   logic wr_diag;
   logic t_busy;
   logic t_done;
   logic [1:0] t_status;
   logic [7:0] t_result;
   assign wr_diag = reg_wr && (reg_addr == pcd_pkg::OFF_DIAG);
   // Plain configuration registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         basic_q <= pcd_pkg::RST_BASIC_CTRL;
         gig_q <= pcd_pkg::RST_GIG_CTRL;
         adv_q <= pcd_pkg::RST_ADVERT;
         loop_q <= pcd_pkg::RST_REM_LOOP;
         mode_q <= pcd_pkg::RST_IND_MODE;
      end else if (reg_wr) begin
         case (reg_addr)
            // restart bit is a pulse, never stored by a write
            pcd_pkg::OFF_BASIC_CTRL: begin
               basic_q <= reg_wdata & ~(16'h0001 << pcd_pkg::BC_AN_RESTART);
            end
            pcd_pkg::OFF_GIG_CTRL: gig_q <= reg_wdata;
            pcd_pkg::OFF_ADVERT: adv_q <= reg_wdata;
            pcd_pkg::OFF_REM_LOOP: loop_q <= reg_wdata;
            pcd_pkg::OFF_IND_MODE: mode_q <= reg_wdata;
            default: basic_q <= basic_q;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) an_restart <= 1'b0;
      else an_restart <= reg_wr && (reg_addr == pcd_pkg::OFF_BASIC_CTRL)
                         && reg_wdata[pcd_pkg::BC_AN_RESTART];
   end
   // start bit set by write, cleared by test end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         start_q <= 1'b0;
         pair_q <= 2'h0;
      end else if (wr_diag && reg_wdata[pcd_pkg::DG_START] && !t_busy) begin
         start_q <= 1'b1;
         pair_q <= reg_wdata[pcd_pkg::DG_PAIR_HI:pcd_pkg::DG_PAIR_LO];
      end else if (t_done) begin
         start_q <= 1'b0;
      end
   end
   // Launch pulse: only from idle, so a second start while busy is ignored
   logic launch;
   assign launch = wr_diag && reg_wdata[pcd_pkg::DG_START] && !t_busy;
   // sequencer keeps status and result until next launch
   pcd_tdr #(
      .QUIET_TIMEOUT(QUIET_TIMEOUT)
   ) u_tdr (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .start(launch),
      .pair(reg_wdata[pcd_pkg::DG_PAIR_HI:pcd_pkg::DG_PAIR_LO]),
      .partner_quiet(s_quiet),
      .echo_seen(s_echo),
      .echo_open(open_q2),
      .busy(t_busy),
      .done(t_done),
      .status(t_status),
      .result(t_result),
      .pulse_pair(pulse_pair)
   );
   // -------------------------------------------------------------
   // Read port: data one cycle after the strobe
   // -------------------------------------------------------------
   logic [15:0] rd_d;
   always_comb begin
      case (reg_addr)
         pcd_pkg::OFF_BASIC_CTRL: rd_d = basic_q;
         pcd_pkg::OFF_GIG_CTRL: rd_d = gig_q;
         pcd_pkg::OFF_DIAG: rd_d = {start_q, 1'b0, pair_q, 2'h0,
                                    t_status, t_result};
         pcd_pkg::OFF_ADVERT: rd_d = adv_q;
         pcd_pkg::OFF_REM_LOOP: rd_d = loop_q;
         pcd_pkg::OFF_IND_MODE: rd_d = mode_q;
         pcd_pkg::OFF_PORT_STAT: rd_d = {11'h000, t_busy, s_link,
                                         s_speed, s_act};
         default: rd_d = 16'h0000;
      endcase
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) reg_rdata <= 16'h0000;
      else if (reg_rd) reg_rdata <= rd_d;
      else reg_rdata <= 16'h0000;
   end
   // -------------------------------------------------------------
   // Remote loopback datapath
   // -------------------------------------------------------------
   logic loop_en;
   assign loop_en = loop_q[pcd_pkg::RL_ENABLE];
   // line data returned, MAC path bypassed
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         line_tx_data <= '0;
         line_tx_valid <= 1'b0;
      end else if (loop_en) begin
         line_tx_data <= line_rx_data;
         line_tx_valid <= line_rx_valid;
      end else begin
         line_tx_data <= mac_tx_data;
         line_tx_valid <= mac_tx_valid;
      end
   end
   // -------------------------------------------------------------
   // Indicators
   // -------------------------------------------------------------
   logic blink_on;
   logic phase;
   pcd_blink #(
      .HALF_PERIOD(BLINK_HALF)
   ) u_blink (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .activity(s_act && s_link),
      .blink_on(blink_on),
      .phase(phase)
   );
   // Lamp-on levels before inversion; blink forces dark on odd phase
   logic lit_a;
   logic lit_b;
   logic single_mode;
   // mode bit selects single or tri-colour
   assign single_mode = mode_q[pcd_pkg::IM_SINGLE];
   always_comb begin
      lit_a = 1'b0;
      lit_b = 1'b0;
      if (s_link) begin
         if (single_mode) begin
            // B shows link, A shows activity only
            lit_b = 1'b1;
            lit_a = blink_on && !phase;
         end else begin
            case (s_speed)
               pcd_pkg::SPD_1000: lit_b = !(blink_on && phase);
               pcd_pkg::SPD_100: lit_a = !(blink_on && phase);
               pcd_pkg::SPD_10: begin
                  lit_a = !(blink_on && phase);
                  lit_b = !(blink_on && phase);
               end
               default: lit_b = 1'b0;
            endcase
         end
      end
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_indicator_a_n <= 1'b1;
         port_indicator_b_n <= 1'b1;
      end else begin
         port_indicator_a_n <= ~lit_a;
         port_indicator_b_n <= ~lit_b;
      end
   end
   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   sequence s_launch;
      wr_diag && reg_wdata[pcd_pkg::DG_START] && !t_busy;
   endsequence
   property p_start_set;
      @(posedge sys_clk) disable iff (!reset_n)
      s_launch |=> start_q;
   endproperty
   a_start_set: assert property (p_start_set)
      else $error("start bit not set by launch");
   property p_start_clear;
      @(posedge sys_clk) disable iff (!reset_n)
      t_done |=> !start_q;
   endproperty
   a_start_clear: assert property (p_start_clear)
      else $error("start bit not cleared at test end");
   property p_one_pair;
      @(posedge sys_clk) disable iff (!reset_n)
      $onehot0(pulse_pair);
   endproperty
   a_one_pair: assert property (p_one_pair)
      else $error("more than one pair pulsed");
   property p_invalid;
      @(posedge sys_clk) disable iff (!reset_n)
      (t_busy && pulse_pair == 4'h0 && !s_quiet && t_done)
         |-> t_status == pcd_pkg::ST_INVALID;
   endproperty
   a_invalid: assert property (p_invalid)
      else $error("unsilenced partner not reported invalid");
   property p_hold;
      @(posedge sys_clk) disable iff (!reset_n)
      (!t_busy && !launch) |=> $stable(t_status) && $stable(t_result);
   endproperty
   a_hold: assert property (p_hold)
      else $error("result changed while idle");
   property p_loop;
      @(posedge sys_clk) disable iff (!reset_n)
      loop_en |=> line_tx_data == $past(line_rx_data);
   endproperty
   a_loop: assert property (p_loop)
      else $error("loopback data not returned");
   property p_dark;
      @(posedge sys_clk) disable iff (!reset_n)
      !s_link |=> port_indicator_a_n && port_indicator_b_n;
   endproperty
   a_dark: assert property (p_dark)
      else $error("indicator lit without link");
   property p_single_b;
      @(posedge sys_clk) disable iff (!reset_n)
      (s_link && single_mode) |=> !port_indicator_b_n;
   endproperty
   a_single_b: assert property (p_single_b)
      else $error("single mode link lamp dark");
   property p_restart;
      @(posedge sys_clk) disable iff (!reset_n)
      (reg_wr && reg_addr == pcd_pkg::OFF_BASIC_CTRL
         && reg_wdata[pcd_pkg::BC_AN_RESTART]) |=> an_restart ##1 !an_restart;
   endproperty
   a_restart: assert property (p_restart)
      else $error("restart pulse missing");
endmodule // pcd_top
`default_nettype wire

// ---- sim/pcd_remote_phy.sv ----
// Far-end link partner and analog echo model for the maintenance block
`default_nettype none
module pcd_remote_phy (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic quiet_ok,
   input wire logic [7:0] echo_dly,
   input wire logic open_sel,
   input wire logic send,
   input wire logic [3:0] pulse_pair,
   output logic partner_quiet,
   output logic echo_seen,
   output logic echo_open,
   output logic [7:0] line_rx_data,
   output logic line_rx_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] pulse_q;
   logic [8:0] cnt_q;
   logic [7:0] data_q;
   // partner silence
   // Partner stays loud unless the bench lets it fall silent
   assign partner_quiet = quiet_ok;
   // echo after delay
   // Time since the pulse ended; saturates so a late test never wraps
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pulse_q <= 4'h0;
         cnt_q <= 9'h000;
      end else begin
         pulse_q <= pulse_pair;
         if (pulse_q != 4'h0 && pulse_pair == 4'h0) begin
            cnt_q <= 9'h001;
         end else if (cnt_q != 9'h000 && cnt_q != 9'h1FF) begin
            cnt_q <= cnt_q + 9'h001;
         end
      end
   end
   // Four-cycle reflection; zero delay means a matched cable
   assign echo_seen = (echo_dly != 8'h00) && (cnt_q >= {1'b0, echo_dly})
      && (cnt_q < {1'b0, echo_dly} + 9'h004);
   assign echo_open = echo_seen ? open_sel : ~open_sel;
   // partner line traffic
   // Data changes every cycle so a stale copy never passes
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_q <= 8'h00;
      end else begin
         data_q <= data_q + 8'h01;
      end
   end
   assign line_rx_data = data_q;
   assign line_rx_valid = send;
endmodule // pcd_remote_phy
`default_nettype wire

// ---- sim/pcd_top_tb_top.sv ----
// Self-checking bench for the PHY maintenance block
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module pcd_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, reset_n, reg_wr, reg_rd, link_up, rx_act, tx_act;
   logic mac_v, ltx_v, lrx_v, quiet_ok, open_sel, send, an_restart;
   logic ind_a_n, ind_b_n, p_quiet, e_seen, e_open, seen;
   logic [3:0] reg_addr, pulse_pair, seen_pp;
   logic [15:0] reg_wdata, reg_rdata, d, d2;
   logic [1:0] link_speed;
   logic [7:0] mac_d, ltx_d, lrx_d, echo_dly, r0, x;
   logic [15:0] rv [8];
   int fails, num_checks;
   pcd_top #(.BLINK_HALF(8), .QUIET_TIMEOUT(16)) u_dut (.sys_clk(sys_clk),
      .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .link_up(link_up), .link_speed(link_speed), .rx_activity(rx_act),
      .tx_activity(tx_act), .partner_quiet(p_quiet), .echo_seen(e_seen),
      .echo_open(e_open), .line_rx_data(lrx_d), .line_rx_valid(lrx_v),
      .mac_tx_data(mac_d), .mac_tx_valid(mac_v), .line_tx_data(ltx_d),
      .line_tx_valid(ltx_v), .pulse_pair(pulse_pair),
      .an_restart(an_restart), .port_indicator_a_n(ind_a_n),
      .port_indicator_b_n(ind_b_n));
   pcd_remote_phy u_far (.sys_clk(sys_clk), .reset_n(reset_n),
      .quiet_ok(quiet_ok), .echo_dly(echo_dly), .open_sel(open_sel),
      .send(send), .pulse_pair(pulse_pair), .partner_quiet(p_quiet),
      .echo_seen(e_seen), .echo_open(e_open), .line_rx_data(lrx_d),
      .line_rx_valid(lrx_v));
   // ------------------------------------------------------------
   // Clock, pulse watcher and bus tasks
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Last pair pulsed, so a wrong or extra pair shows up
   always @(posedge sys_clk) if (pulse_pair !== 4'h0) seen_pp <= pulse_pair;
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // launch on one pair, poll start bit; bounded poll
   task automatic diag(input logic [1:0] p, output logic [15:0] v);
      int n;
      n = 0;
      seen_pp = 4'h0;
      wr(pcd_pkg::OFF_DIAG, {2'b10, p, 12'h000});
      rd(pcd_pkg::OFF_DIAG, v);
      `CHK(v[15], 1'b1)
      while (v[15] === 1'b1 && n < 400) begin
         rd(pcd_pkg::OFF_DIAG, v);
         n++;
      end
      `CHK(v[15], 1'b0)
   endtask
   // Indicators settle three cycles after their inputs; ends on an edge
   task automatic led(input logic [1:0] e);
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk) `CHK({ind_b_n, ind_a_n}, e)
      @(posedge sys_clk);
   endtask
   // One short burst must give a visible change of the activity lamp
   task automatic blink(input logic lvl);
      seen = 1'b0;
      tx_act <= 1'b1;
      @(posedge sys_clk);
      tx_act <= 1'b0;
      repeat (40) @(negedge sys_clk) seen |= (ind_a_n === lvl);
      @(posedge sys_clk);
      `CHK(seen, 1'b1)
   endtask
   task automatic results;
      if (fails == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog: the whole run needs well under 20000 cycles
   initial begin
      #300us;
      fails++;
      results();
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      {reset_n, reg_wr, reg_rd, rx_act, tx_act, mac_v, send} = '0;
      {reg_addr, reg_wdata, link_speed, mac_d, open_sel} = '0;
      {link_up, quiet_ok, echo_dly} = '0;
      rv = '{16'h1340, 16'h0700, 16'h0000, 16'h01E1, 16'h0000,
         16'h0000, 16'h0000, 16'h0000};
      repeat (5) @(posedge sys_clk);
      `CHK({ind_b_n, ind_a_n}, 2'b11)
      reset_n <= 1'b1;
      wr(4'h7, 16'hFFFF);
      for (int i = 0; i < 8; i++) begin
         rd(i[3:0], d);
         if (i != 6) `CHK(d, rv[i])
      end
      // Diagnostic set-up: negotiation off, manual master/slave
      wr(pcd_pkg::OFF_BASIC_CTRL, 16'h0140);
      wr(pcd_pkg::OFF_GIG_CTRL, 16'h1000);
      quiet_ok <= 1'b1;
      rd(pcd_pkg::OFF_BASIC_CTRL, d);
      `CHK(d, 16'h0140)
      // Every pair, open and short in turn, echo later on each pair
      for (int p = 0; p < 4; p++) begin
         open_sel <= p[0];
         echo_dly <= 8'(30 + 10 * p);
         diag(p[1:0], d);
         `CHK(seen_pp, 4'h1 << p)
         `CHK(d[9:8], p[0] ? pcd_pkg::ST_OPEN : pcd_pkg::ST_SHORT)
         if (p == 0) r0 = d[7:0];
         `CHK(8'(d[7:0] - r0), 8'(10 * p))
      end
      echo_dly <= 8'h00;
      diag(2'h2, d);
      `CHK(d[9:8], pcd_pkg::ST_NORMAL)
      @(posedge sys_clk) quiet_ok <= 1'b0;
      diag(2'h3, d);
      `CHK(d[9:8], pcd_pkg::ST_INVALID)
      `CHK(seen_pp, 4'h0)
      repeat (50) @(posedge sys_clk);
      rd(pcd_pkg::OFF_DIAG, d2);
      `CHK(d2, d)
      // Restore defaults; the basic word restarts negotiation
      wr(pcd_pkg::OFF_GIG_CTRL, 16'h0700);
      wr(pcd_pkg::OFF_BASIC_CTRL, 16'h1340);
      #1 `CHK(an_restart, 1'b1)
      @(posedge sys_clk);
      #1 `CHK(an_restart, 1'b0)
      rd(pcd_pkg::OFF_BASIC_CTRL, d);
      `CHK(d, 16'h1140)
      // Gigabit master loopback returns partner data
      @(posedge sys_clk);
      send <= 1'b1;
      mac_d <= 8'hA5;
      mac_v <= 1'b1;
      wr(pcd_pkg::OFF_GIG_CTRL, 16'h1F00);
      wr(pcd_pkg::OFF_REM_LOOP, 16'h01F0);
      wr(pcd_pkg::OFF_BASIC_CTRL, 16'h1340);
      rd(pcd_pkg::OFF_GIG_CTRL, d);
      `CHK(d, 16'h1F00)
      @(negedge sys_clk) x = lrx_d;
      @(posedge sys_clk);
      #1 `CHK({ltx_v, ltx_d}, {1'b1, x})
      // 100 Mb/s words, then loopback off gives local data
      wr(pcd_pkg::OFF_ADVERT, 16'h0181);
      wr(pcd_pkg::OFF_GIG_CTRL, 16'h0C00);
      wr(pcd_pkg::OFF_BASIC_CTRL, 16'h3300);
      rd(pcd_pkg::OFF_ADVERT, d);
      `CHK(d, 16'h0181)
      wr(pcd_pkg::OFF_REM_LOOP, 16'h0000);
      repeat (2) @(posedge sys_clk);
      #1 `CHK(ltx_d, 8'hA5)
      // Indicator modes across link speeds
      wr(pcd_pkg::OFF_IND_MODE, 16'h0010);
      link_up <= 1'b1;
      link_speed <= pcd_pkg::SPD_1000;
      led(2'b01);
      blink(1'b0);
      wr(pcd_pkg::OFF_IND_MODE, 16'h0000);
      led(2'b01);
      link_speed <= pcd_pkg::SPD_100;
      led(2'b10);
      blink(1'b1);
      link_speed <= pcd_pkg::SPD_10;
      led(2'b00);
      link_up <= 1'b0;
      led(2'b11);
      results();
   end
endmodule // pcd_top_tb_top
`default_nettype wire
